// ---- design/rf_pkg.sv ----
// shared constants, types and carriers for the register file and data access unit
package rf_pkg;
	localparam int REG_COUNT = 32;
	localparam int IO_COUNT = 64;
	localparam int SRAM_COUNT = 1024;
	localparam int DISP_WIDTH = 6;
	localparam int PC_WIDTH = 13;
	localparam logic [15:0] IO_BASE = 16'h0020;
	localparam logic [15:0] SRAM_BASE = 16'h0060;
	localparam logic [15:0] DATA_END = 16'h0460;
	localparam logic [4:0] PTR_A_LOW_IDX = 5'h1A;
	localparam logic [4:0] PTR_B_LOW_IDX = 5'h1C;
	localparam logic [4:0] PTR_C_LOW_IDX = 5'h1E;
	localparam logic UPPER_HALF_BIT = 1'h1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] IO_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [12:0] PC_RESET = 13'h0000;

	typedef enum logic [2:0] {
		MODE_DIRECT,
		MODE_DISP,
		MODE_INDIRECT,
		MODE_PREDEC,
		MODE_POSTINC
	} addr_mode_t;

	typedef enum logic [1:0] {
		PTR_A,
		PTR_B,
		PTR_C
	} ptr_sel_t;

	typedef enum logic [1:0] {
		MUL_UNSIGNED,
		MUL_SIGNED,
		MUL_SIGNED_UNSIGNED,
		MUL_FRACTIONAL
	} mul_mode_t;

	typedef enum logic [1:0] {
		REGION_REG,
		REGION_IO,
		REGION_SRAM,
		REGION_NONE
	} region_t;

	typedef struct packed {
		logic valid;
		logic imm_form;
		logic [4:0] dest_field;
		logic [4:0] source_reg_field;
	} alu_read_t;

	typedef struct packed {
		logic valid;
		logic imm_form;
		logic [4:0] dest_field;
		logic [7:0] result;
	} alu_write_t;

	typedef struct packed {
		logic valid;
		logic write;
		addr_mode_t mode;
		ptr_sel_t ptr;
		logic [5:0] disp;
		logic [15:0] addr;
		logic [7:0] wdata;
	} data_req_t;

	typedef struct packed {
		logic valid;
		mul_mode_t mode;
		logic [4:0] dest_field;
		logic [4:0] source_reg_field;
	} mul_req_t;

	typedef struct packed {
		logic load;
		logic two_words;
		logic step;
		logic [12:0] target;
	} pc_ctl_t;
endpackage : rf_pkg

// ---- design/rf_data_core.sv ----
// working registers, pointer pairs, data space map and data addressing modes
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - 32 byte registers at data addresses 0..31
// - any register reachable, single cycle access
// - immediate forms address registers 16..31 only
// - two- and one-register forms reach all 32
// - registers 26..31 form three low/high pointers
// - pointers can index any working register
// - two operands out, result in, one cycle
// - registers feed signed/unsigned/fractional multiplier
// - 13-bit program counter, one or two words
// - 96 register/io addresses, then 1024 sram
// - five data addressing modes exactly
// - direct address reaches whole data space
// - displacement: pointers b or c, 0..63
// - adjusted pointer written back into its pair
// - every location reachable in every mode
// - single register operand from destination field
// - pre-decrement: decrement first, then use
// - post-increment: use first, then increment
// - address is base plus unsigned 6-bit field
module rf_data_core (
	input wire logic clk,
	input wire logic rst,
	input wire rf_pkg::alu_read_t alu_read,
	input wire rf_pkg::alu_write_t alu_write,
	input wire rf_pkg::mul_req_t mul_req,
	input wire rf_pkg::data_req_t data_req,
	input wire rf_pkg::pc_ctl_t pc_ctl,
	output logic [7:0] operand_a_reg,
	output logic [7:0] operand_b_reg,
	output logic operand_valid_reg,
	output logic [15:0] product_reg,
	output logic product_valid_reg,
	output logic [7:0] data_rdata_reg,
	output logic data_rvalid_reg,
	output logic [15:0] data_addr_reg,
	output logic data_refused_reg,
	output logic [12:0] program_counter_reg
);
	logic [7:0] regs [rf_pkg::REG_COUNT];
	logic [7:0] io_mem [rf_pkg::IO_COUNT];
	logic [7:0] sram [rf_pkg::SRAM_COUNT];
	logic [15:0] ptr_value;
	logic [15:0] ptr_next;
	logic [15:0] eff_addr;
	logic [4:0] ptr_low_idx;
	logic ptr_update;
	logic access_ok;
	logic [4:0] alu_dest_idx;
	logic [4:0] rd_dest_idx;
	logic [4:0] rd_src_idx;
	rf_pkg::region_t region;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic rf_pkg::region_t region_of(input logic [15:0] addr);
		if (addr < rf_pkg::IO_BASE) begin
			return rf_pkg::REGION_REG;
		end else if (addr < rf_pkg::SRAM_BASE) begin
			return rf_pkg::REGION_IO;
		end else if (addr < rf_pkg::DATA_END) begin
			return rf_pkg::REGION_SRAM;
		end
		return rf_pkg::REGION_NONE;
	endfunction : region_of

	function automatic logic [4:0] dest_index(input logic imm_form, input logic [4:0] field);
		if (imm_form) begin
			return {rf_pkg::UPPER_HALF_BIT, field[3:0]};
		end
		return field;
	endfunction : dest_index

	function automatic logic [4:0] ptr_index(input rf_pkg::ptr_sel_t sel);
		unique case (sel)
			rf_pkg::PTR_A: return rf_pkg::PTR_A_LOW_IDX;
			rf_pkg::PTR_B: return rf_pkg::PTR_B_LOW_IDX;
			rf_pkg::PTR_C: return rf_pkg::PTR_C_LOW_IDX;
			default: return rf_pkg::PTR_C_LOW_IDX;
		endcase
	endfunction : ptr_index

	function automatic logic [15:0] signed_wide(input logic [7:0] value);
		return {{8{value[7]}}, value};
	endfunction : signed_wide

	////////////////////////////////////////////////////////////////////////
	// effective address and pointer adjustment
	assign alu_dest_idx = dest_index(alu_write.imm_form, alu_write.dest_field);
	assign rd_dest_idx = dest_index(alu_read.imm_form, alu_read.dest_field);
	assign rd_src_idx = alu_read.source_reg_field;
	assign ptr_low_idx = ptr_index(data_req.ptr);
	assign ptr_value = {regs[ptr_low_idx + 5'h01], regs[ptr_low_idx]};

	always_comb begin
		eff_addr = ptr_value;
		ptr_next = ptr_value;
		ptr_update = 1'b0;
		access_ok = data_req.valid;
		unique case (data_req.mode)
			rf_pkg::MODE_DIRECT: begin
				eff_addr = data_req.addr;
			end
			rf_pkg::MODE_DISP: begin
				eff_addr = ptr_value + {10'h000, data_req.disp};
				access_ok = data_req.valid && (data_req.ptr != rf_pkg::PTR_A);
			end
			rf_pkg::MODE_INDIRECT: begin
				eff_addr = ptr_value;
			end
			rf_pkg::MODE_PREDEC: begin
				ptr_next = ptr_value - 16'h0001;
				eff_addr = ptr_next;
				ptr_update = data_req.valid;
			end
			rf_pkg::MODE_POSTINC: begin
				ptr_next = ptr_value + 16'h0001;
				eff_addr = ptr_value;
				ptr_update = data_req.valid;
			end
			default: begin
				access_ok = 1'b0;
			end
		endcase
		if (data_req.ptr == 2'h3 && data_req.mode != rf_pkg::MODE_DIRECT) begin
			access_ok = 1'b0;
			ptr_update = 1'b0;
		end
	end

	assign region = region_of(eff_addr);

	////////////////////////////////////////////////////////////////////////
	// working registers
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < rf_pkg::REG_COUNT; i++) begin
				regs[i] <= rf_pkg::REG_RESET;
			end
		end else begin
			if (access_ok && data_req.write && region == rf_pkg::REGION_REG) begin
				regs[eff_addr[4:0]] <= data_req.wdata;
			end
			if (ptr_update) begin
				regs[ptr_low_idx] <= ptr_next[7:0];
				regs[ptr_low_idx + 5'h01] <= ptr_next[15:8];
			end
			if (alu_write.valid) begin
				regs[alu_dest_idx] <= alu_write.result;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// io locations
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < rf_pkg::IO_COUNT; i++) begin
				io_mem[i] <= rf_pkg::IO_RESET;
			end
		end else if (access_ok && data_req.write && region == rf_pkg::REGION_IO) begin
			io_mem[6'(eff_addr - rf_pkg::IO_BASE)] <= data_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sram bytes
	always_ff @(posedge clk) begin
		if (access_ok && data_req.write && region == rf_pkg::REGION_SRAM) begin
			sram[10'(eff_addr - rf_pkg::SRAM_BASE)] <= data_req.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data read path
	always_ff @(posedge clk) begin
		if (rst) begin
			data_rdata_reg <= rf_pkg::UNMAPPED_READ;
			data_rvalid_reg <= 1'b0;
			data_addr_reg <= 16'h0000;
			data_refused_reg <= 1'b0;
		end else begin
			data_rvalid_reg <= access_ok && !data_req.write;
			data_refused_reg <= data_req.valid && !access_ok;
			if (data_req.valid) begin
				data_addr_reg <= eff_addr;
			end
			if (access_ok && !data_req.write) begin
				unique case (region)
					rf_pkg::REGION_REG: data_rdata_reg <= regs[eff_addr[4:0]];
					rf_pkg::REGION_IO: data_rdata_reg <= io_mem[6'(eff_addr - rf_pkg::IO_BASE)];
					rf_pkg::REGION_SRAM: data_rdata_reg <= sram[10'(eff_addr - rf_pkg::SRAM_BASE)];
					rf_pkg::REGION_NONE: data_rdata_reg <= rf_pkg::UNMAPPED_READ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operand path with result forwarding
	always_ff @(posedge clk) begin
		if (rst) begin
			operand_a_reg <= rf_pkg::REG_RESET;
			operand_b_reg <= rf_pkg::REG_RESET;
			operand_valid_reg <= 1'b0;
		end else begin
			operand_valid_reg <= alu_read.valid;
			if (alu_read.valid) begin
				operand_a_reg <= (alu_write.valid && alu_dest_idx == rd_dest_idx) ?
					alu_write.result : regs[rd_dest_idx];
				operand_b_reg <= (alu_write.valid && alu_dest_idx == rd_src_idx) ?
					alu_write.result : regs[rd_src_idx];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// multiplier feed
	logic [7:0] mul_a;
	logic [7:0] mul_b;
	assign mul_a = regs[mul_req.dest_field];
	assign mul_b = regs[mul_req.source_reg_field];

	always_ff @(posedge clk) begin
		if (rst) begin
			product_reg <= 16'h0000;
			product_valid_reg <= 1'b0;
		end else begin
			product_valid_reg <= mul_req.valid;
			if (mul_req.valid) begin
				unique case (mul_req.mode)
					rf_pkg::MUL_UNSIGNED: product_reg <= mul_a * mul_b;
					rf_pkg::MUL_SIGNED:
						product_reg <= 16'($signed(signed_wide(mul_a)) *
							$signed(signed_wide(mul_b)));
					rf_pkg::MUL_SIGNED_UNSIGNED:
						product_reg <= 16'($signed({{8{mul_a[7]}}, mul_a}) *
							$signed({8'h00, mul_b}));
					rf_pkg::MUL_FRACTIONAL:
						product_reg <= 16'($signed(signed_wide(mul_a)) *
							$signed(signed_wide(mul_b))) << 1;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter
	always_ff @(posedge clk) begin
		if (rst) begin
			program_counter_reg <= rf_pkg::PC_RESET;
		end else if (pc_ctl.load) begin
			program_counter_reg <= pc_ctl.target;
		end else if (pc_ctl.step) begin
			program_counter_reg <= program_counter_reg +
				(pc_ctl.two_words ? 13'h0002 : 13'h0001);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_postinc_c;
		data_req.valid && data_req.mode == rf_pkg::MODE_POSTINC &&
			data_req.ptr == rf_pkg::PTR_C && !alu_write.valid &&
			!(data_req.write && eff_addr[15:5] == 11'h000);
	endsequence

	sequence s_predec_read;
		data_req.valid && data_req.mode == rf_pkg::MODE_PREDEC && !data_req.write &&
			data_req.ptr != 2'h3;
	endsequence

	sequence s_sram_write;
		access_ok && data_req.write && region == rf_pkg::REGION_SRAM;
	endsequence

	a_upper_half_dest: assert property (alu_write.valid && alu_write.imm_form |=>
		regs[{1'b1, $past(alu_write.dest_field[3:0])}] == $past(alu_write.result))
		else $error("immediate form missed upper register");

	a_full_range_dest: assert property (alu_write.valid && !alu_write.imm_form |=>
		regs[$past(alu_write.dest_field)] == $past(alu_write.result))
		else $error("register form write lost");

	a_operand_cycle: assert property (alu_read.valid && !alu_write.valid |=>
		operand_valid_reg && operand_b_reg == $past(regs[alu_read.source_reg_field]))
		else $error("operand not delivered next cycle");

	a_postinc_ptr: assert property (s_postinc_c |=>
		{regs[31], regs[30]} == $past({regs[31], regs[30]}) + 16'h0001 &&
		data_addr_reg == $past({regs[31], regs[30]}))
		else $error("post-increment pointer or address wrong");

	a_predec_addr: assert property (s_predec_read |=>
		data_addr_reg == $past(ptr_value) - 16'h0001 && data_rvalid_reg)
		else $error("pre-decrement address wrong");

	a_disp_base: assert property (data_req.valid && data_req.mode == rf_pkg::MODE_DISP |=>
		(data_refused_reg == ($past(data_req.ptr) != rf_pkg::PTR_B &&
		$past(data_req.ptr) != rf_pkg::PTR_C)) &&
		data_addr_reg == $past(ptr_value) + {10'h000, $past(data_req.disp)})
		else $error("displacement access wrong");

	a_sram_roundtrip: assert property (s_sram_write ##1 (access_ok && !data_req.write &&
		eff_addr == $past(eff_addr)) |=> data_rdata_reg == $past(data_req.wdata, 2))
		else $error("sram byte not read back");

	a_unmapped_read: assert property (access_ok && !data_req.write &&
		region == rf_pkg::REGION_NONE |=> data_rdata_reg == rf_pkg::UNMAPPED_READ)
		else $error("unmapped read not neutral");

	a_pc_step: assert property (pc_ctl.step && !pc_ctl.load |=>
		program_counter_reg == $past(program_counter_reg) + ($past(pc_ctl.two_words) ?
		13'h0002 : 13'h0001))
		else $error("program counter step wrong");

	a_mul_unsigned: assert property (mul_req.valid && mul_req.mode == rf_pkg::MUL_UNSIGNED |=>
		product_valid_reg && product_reg == $past(mul_a) * $past(mul_b))
		else $error("unsigned product wrong");

	a_mul_signed: assert property (mul_req.valid && mul_req.mode == rf_pkg::MUL_SIGNED |=>
		$signed(product_reg) == $signed($past(mul_a)) * $signed($past(mul_b)))
		else $error("signed product wrong");

	a_pc_load: assert property (pc_ctl.load |=>
		program_counter_reg == $past(pc_ctl.target))
		else $error("program counter load lost");

	a_direct_addr: assert property (data_req.valid &&
		data_req.mode == rf_pkg::MODE_DIRECT |=>
		data_addr_reg == $past(data_req.addr) && !data_refused_reg)
		else $error("direct address wrong");

	a_refused_quiet: assert property (data_req.valid && !access_ok &&
		!alu_write.valid |=> data_refused_reg && !data_rvalid_reg &&
		{regs[31], regs[30]} == $past({regs[31], regs[30]}))
		else $error("refused access changed state");

	a_imm_operand: assert property (alu_read.valid && alu_read.imm_form &&
		!alu_write.valid |=>
		operand_a_reg == $past(regs[{1'b1, alu_read.dest_field[3:0]}]))
		else $error("immediate operand not from upper half");
endmodule : rf_data_core

// ---- testbench/alu_partner.sv ----
// decoder and alu model that adds the two operands and returns the sum
module alu_partner (
	input wire logic clk,
	input wire logic rst,
	input wire rf_pkg::alu_read_t alu_read,
	input wire logic [7:0] operand_a,
	input wire logic [7:0] operand_b,
	input wire logic operand_valid,
	output rf_pkg::alu_write_t alu_write
);
	timeunit 1ns;
	timeprecision 100ps;
	logic imm_reg;
	logic [4:0] dest_reg;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (rst) begin
			imm_reg <= 1'h0;
			dest_reg <= 5'h00;
			alu_write <= '0;
		end else begin
			if (alu_read.valid) begin
				imm_reg <= alu_read.imm_form;
				dest_reg <= alu_read.dest_field;
			end
			alu_write.valid <= operand_valid;
			alu_write.imm_form <= imm_reg;
			alu_write.dest_field <= dest_reg;
			alu_write.result <= operand_a + operand_b;
		end
	end
endmodule : alu_partner

// ---- testbench/test_cpu_register_file_data_addressing.sv ----
// bench for the register file, data space map and addressing modes
module test_cpu_register_file_data_addressing;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
		$display("BAD %0t got %h want %h", $time, g, e); end end
	logic clk;
	logic rst;
	rf_pkg::alu_read_t alu_read;
	rf_pkg::alu_write_t alu_write;
	rf_pkg::mul_req_t mul_req;
	rf_pkg::data_req_t data_req;
	rf_pkg::pc_ctl_t pc_ctl;
	logic [7:0] opa, opb, rdata;
	logic [15:0] product, daddr;
	logic opv, pvalid, rvalid, refused;
	logic [12:0] pc_val;
	int err_count = 0;
	int cmp_count = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////////
	rf_data_core DUT (.clk(clk), .rst(rst), .alu_read(alu_read), .alu_write(alu_write),
		.mul_req(mul_req), .data_req(data_req), .pc_ctl(pc_ctl), .operand_a_reg(opa),
		.operand_b_reg(opb), .operand_valid_reg(opv), .product_reg(product),
		.product_valid_reg(pvalid), .data_rdata_reg(rdata), .data_rvalid_reg(rvalid),
		.data_addr_reg(daddr), .data_refused_reg(refused), .program_counter_reg(pc_val));
	alu_partner u_alu (.clk(clk), .rst(rst), .alu_read(alu_read), .operand_a(opa),
		.operand_b(opb), .operand_valid(opv), .alu_write(alu_write));
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	task automatic dacc(input logic w, input rf_pkg::addr_mode_t m, input rf_pkg::ptr_sel_t p,
			input logic [5:0] d, input logic [15:0] a, input logic [7:0] wd,
			input logic [15:0] ea, input logic [7:0] er, input logic rf);
		@(posedge clk);
		data_req <= '{1'b1, w, m, p, d, a, wd};
		@(posedge clk);
		data_req.valid <= 1'b0;
		#1;
		`CHK(refused, rf)
		`CHK(rvalid, ~w & ~rf)
		if (!rf) `CHK(daddr, ea)
		if (!w && !rf) `CHK(rdata, er)
	endtask : dacc
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		dacc(1'b1, rf_pkg::MODE_DIRECT, rf_pkg::PTR_A, 6'h00, a, d, a, 8'h00, 1'b0);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		dacc(1'b0, rf_pkg::MODE_DIRECT, rf_pkg::PTR_A, 6'h00, a, 8'h00, a, e, 1'b0);
	endtask : rd
	task automatic alu(input logic imm, input logic [4:0] d, input logic [4:0] s,
			input logic [7:0] ea, input logic [7:0] eb);
		@(posedge clk);
		alu_read <= '{1'b1, imm, d, s};
		@(posedge clk);
		alu_read.valid <= 1'b0;
		#1;
		`CHK(opv, 1'b1)
		`CHK(opa, ea)
		`CHK(opb, eb)
		repeat (3) @(posedge clk);
	endtask : alu
	task automatic mul(input rf_pkg::mul_mode_t m, input logic [15:0] e);
		@(posedge clk);
		mul_req <= '{1'b1, m, 5'h04, 5'h05};
		@(posedge clk);
		mul_req.valid <= 1'b0;
		#1;
		`CHK(pvalid, 1'b1)
		`CHK(product, e)
	endtask : mul
	task automatic pc(input logic ld, input logic two, input logic [12:0] t, input logic [12:0] e);
		@(posedge clk);
		pc_ctl <= '{ld, two, ~ld, t};
		@(posedge clk);
		pc_ctl <= '0;
		#1;
		`CHK(pc_val, e)
	endtask : pc
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		#1;
		`CHK(pc_val, 13'h0000)
		`CHK(opv, 1'b0)
		`CHK(pvalid, 1'b0)
		rd(16'h001A, 8'h00);
	endtask : t_reset
	task automatic t_map();
		wr(16'h0000, 8'h11);
		rd(16'h0000, 8'h11);
		wr(16'h005F, 8'h3C);
		rd(16'h005F, 8'h3C);
		wr(16'h0060, 8'h22);
		wr(16'h045F, 8'h7E);
		rd(16'h045F, 8'h7E);
		wr(16'h0460, 8'h99);
		rd(16'h0460, 8'h00);
		rd(16'h0060, 8'h22);
	endtask : t_map
	task automatic t_pointer();
		wr(16'h001E, 8'hFF);
		wr(16'h001F, 8'h00);
		dacc(1'b1, rf_pkg::MODE_POSTINC, rf_pkg::PTR_C, 6'h00, 16'h0000, 8'hA5,
			16'h00FF, 8'h00, 1'b0);
		rd(16'h001E, 8'h00);
		rd(16'h001F, 8'h01);
		dacc(1'b0, rf_pkg::MODE_PREDEC, rf_pkg::PTR_C, 6'h00, 16'h0000, 8'h00,
			16'h00FF, 8'hA5, 1'b0);
		rd(16'h001E, 8'hFF);
		wr(16'h013E, 8'h5A);
		dacc(1'b0, rf_pkg::MODE_DISP, rf_pkg::PTR_C, 6'h3F, 16'h0000, 8'h00,
			16'h013E, 8'h5A, 1'b0);
		dacc(1'b0, rf_pkg::MODE_DISP, rf_pkg::PTR_B, 6'h00, 16'h0000, 8'h00,
			16'h0000, 8'h11, 1'b0);
		dacc(1'b0, rf_pkg::MODE_INDIRECT, rf_pkg::PTR_A, 6'h00, 16'h0000, 8'h00,
			16'h0000, 8'h11, 1'b0);
		dacc(1'b1, rf_pkg::MODE_DISP, rf_pkg::PTR_A, 6'h01, 16'h0000, 8'h77,
			16'h0001, 8'h00, 1'b1);
		rd(16'h0001, 8'h00);
	endtask : t_pointer
	task automatic t_refuse();
		dacc(1'b1, rf_pkg::MODE_POSTINC, rf_pkg::ptr_sel_t'(2'h3), 6'h00, 16'h0000, 8'h66,
			16'h0000, 8'h00, 1'b1);
		dacc(1'b0, rf_pkg::addr_mode_t'(3'h7), rf_pkg::PTR_C, 6'h00, 16'h0000, 8'h00,
			16'h0000, 8'h00, 1'b1);
		dacc(1'b0, rf_pkg::MODE_DISP, rf_pkg::ptr_sel_t'(2'h3), 6'h01, 16'h0000, 8'h00,
			16'h0000, 8'h00, 1'b1);
		rd(16'h001E, 8'hFF);
		rd(16'h001F, 8'h00);
		rd(16'h00FF, 8'hA5);
		dacc(1'b0, rf_pkg::MODE_POSTINC, rf_pkg::PTR_B, 6'h00, 16'h0000, 8'h00,
			16'h0000, 8'h11, 1'b0);
		rd(16'h001C, 8'h01);
		dacc(1'b0, rf_pkg::MODE_PREDEC, rf_pkg::PTR_A, 6'h00, 16'h0000, 8'h00,
			16'hFFFF, 8'h00, 1'b0);
		rd(16'h001B, 8'hFF);
	endtask : t_refuse
	task automatic t_alu();
		wr(16'h0003, 8'h12);
		wr(16'h0013, 8'h40);
		wr(16'h001F, 8'h05);
		alu(1'b0, 5'h03, 5'h1F, 8'h12, 8'h05);
		rd(16'h0003, 8'h17);
		alu(1'b1, 5'h03, 5'h1F, 8'h40, 8'h05);
		rd(16'h0013, 8'h45);
		rd(16'h0003, 8'h17);
	endtask : t_alu
	task automatic t_b2b();
		@(posedge clk);
		alu_read <= '{1'b1, 1'b0, 5'h03, 5'h1F};
		@(posedge clk);
		alu_read.valid <= 1'b0;
		@(posedge clk);
		alu_read <= '{1'b1, 1'b0, 5'h1F, 5'h03};
		@(posedge clk);
		alu_read.valid <= 1'b0;
		#1;
		`CHK(opa, 8'h05)
		`CHK(opb, 8'h1C)
		repeat (3) @(posedge clk);
		rd(16'h001F, 8'h21);
		rd(16'h0003, 8'h1C);
		@(posedge clk);
		data_req <= '{1'b1, 1'b1, rf_pkg::MODE_DIRECT, rf_pkg::PTR_A, 6'h00, 16'h0200, 8'hC3};
		@(posedge clk);
		data_req.write <= 1'b0;
		@(posedge clk);
		data_req.valid <= 1'b0;
		#1;
		`CHK(rvalid, 1'b1)
		`CHK(rdata, 8'hC3)
	endtask : t_b2b
	task automatic t_mul();
		wr(16'h0004, 8'hFE);
		wr(16'h0005, 8'h83);
		mul(rf_pkg::MUL_UNSIGNED, 16'h81FA);
		mul(rf_pkg::MUL_SIGNED, 16'h00FA);
		mul(rf_pkg::MUL_SIGNED_UNSIGNED, 16'hFEFA);
		mul(rf_pkg::MUL_FRACTIONAL, 16'h01F4);
	endtask : t_mul
	task automatic t_pc();
		pc(1'b0, 1'b1, 13'h0000, 13'h0002);
		pc(1'b0, 1'b0, 13'h0000, 13'h0003);
		pc(1'b1, 1'b0, 13'h1FFF, 13'h1FFF);
		pc(1'b0, 1'b1, 13'h0000, 13'h0001);
	endtask : t_pc
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			stop_test();
		end
	end
	initial begin
		rst = 1'b1;
		alu_read = '0;
		mul_req = '0;
		data_req = '0;
		pc_ctl = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_map();
		t_pointer();
		t_refuse();
		t_alu();
		t_b2b();
		t_mul();
		t_pc();
		stop_test();
	end
endmodule : test_cpu_register_file_data_addressing
